// [pkg/lgh_regs_map.svh]
// Register offsets, field positions and reset values of the line gain and
// headphone start-up register bank.
// Offsets are register indices on a 32-bit AXI4-Lite bus, one register a
// word, so the byte address of each register is four times its index.
`ifndef LGH_REGS_MAP_SVH
`define LGH_REGS_MAP_SVH

`define LGH_OFF_LINE_GAIN 8'h13
`define LGH_OFF_HP_START 8'h14
`define LGH_OFF_RSVD 8'h15
`define LGH_ADDR_LINE_GAIN (`LGH_OFF_LINE_GAIN * 8'h04)
`define LGH_ADDR_HP_START (`LGH_OFF_HP_START * 8'h04)
`define LGH_ADDR_RSVD (`LGH_OFF_RSVD * 8'h04)
`define LGH_ADDR_W 8
`define LGH_LG_RSVD_BIT 7
`define LGH_LG_MUTE_BIT 6
`define LGH_LG_GAIN_MSB 5
`define LGH_LG_GAIN_LSB 0
`define LGH_HP_STEP_MSB 7
`define LGH_HP_STEP_LSB 6
`define LGH_HP_SLOW_MSB 5
`define LGH_HP_SLOW_LSB 2
`define LGH_HP_RCHG_MSB 1
`define LGH_HP_RCHG_LSB 0
`define LGH_RST_MUTE 1'h1
`define LGH_RST_GAIN 6'h00
`define LGH_RST_STEP 2'h0
`define LGH_RST_SLOW 4'h0
`define LGH_RST_RCHG 2'h0
`define LGH_RST_RSVD 8'h00
`define LGH_GAIN_MIN 6'h3A
`define LGH_GAIN_MAX 6'h1D
`define LGH_SLOW_16TC 4'hE
`define LGH_RCHG_25K 2'h0
`define LGH_RCHG_RSVD 2'h3
`define LGH_RESP_OKAY 2'h0
`define LGH_RESP_SLVERR 2'h2
`define LGH_STEP_50MS 32'd50
`define LGH_CLK_KHZ 32'd25000

`endif

// [pkg/lgh_pkg.sv]
// Types shared by the line gain and headphone start-up register bank.
// Assumes the register map header is compiled alongside.
package lgh_pkg;

    typedef struct packed {
        logic mute;
        logic [5:0] gain;
    } lgh_line_t;

    typedef struct packed {
        logic [1:0] step_sel;
        logic [3:0] slow_sel;
        logic [1:0] rchg_sel;
    } lgh_hp_t;

    typedef enum logic [1:0] {
        LGH_STEP_0 = 2'b00,
        LGH_STEP_50 = 2'b01,
        LGH_STEP_100 = 2'b10,
        LGH_STEP_200 = 2'b11
    } lgh_step_t;

    typedef enum logic [1:0] {
        LGH_B_IDLE = 2'b00,
        LGH_B_RESP = 2'b01
    } lgh_bus_t;

endpackage

// [design/lgh_regs.sv]
// Register bank holding right line-output gain and headphone start-up
// control, reached over AXI4-Lite.
// Assumes a single 25 MHz clock; analog drivers sample the field outputs.
// Operation
// - Line gain bit 7 is reserved, reads zero and is written only as zero.
// - Line gain bit 6 mutes the right line output and resets to one.
// - Bits 5:0 set 1 dB gain steps, 0x3A is -6 dB, 0x1D is +29 dB, reset 0 dB.
// - Start-up bits 7:6 pick a 0, 50, 100 or 200 ms step time, reset 00.
// - Bits 5:2 pick slow power-up: 0000 off, others 0.5 to 32 time constants.
// - Bits 1:0 pick 25K, 6K or 2K charging, reset 25K, code 11 is reserved.
// - The register after the start-up register is reserved and reads zero.
//
// Design decision made here: the AXI4-Lite register port.
`include "lgh_regs_map.svh"
`timescale 1ns/10ps
module lgh_regs
    import lgh_pkg::*;
(
    input wire logic clk_sys, // System clock, 25 MHz.
    input wire logic arst_n, // Asynchronous reset, active low.
    input wire logic [7:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [7:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    output logic right_line_output_mute, // Right line-output mute.
    output logic [5:0] right_line_output_gain, // Right line-output gain.
    output logic [1:0] hp_step_sel, // Soft-routing step time select.
    output logic [3:0] hp_slow_sel, // Slow power-up select.
    output logic [1:0] hp_rchg_sel, // Charging resistance select.
    output logic soft_step_tick // Pulse once per soft-routing step.
);

    localparam int STEP_CYC = `LGH_STEP_50MS * `LGH_CLK_KHZ;
    localparam int STEP_W = 24;

    lgh_line_t line_reg, next_line_reg;
    lgh_hp_t hp_reg, next_hp_reg;

    // Write and read channel state.
    logic aw_held, next_aw_held;
    logic w_held, next_w_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    lgh_bus_t rd_state, next_rd_state;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;
    logic awready, next_awready;
    logic wready, next_wready;
    logic arready, next_arready;
    logic rvalid, next_rvalid;

    // Step timer state.
    logic [STEP_W-1:0] step_cnt, next_step_cnt;
    logic step_tick, next_step_tick;

    logic do_write;
    logic [STEP_W-1:0] step_len;

    assign do_write = aw_held && w_held && !bvalid;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_line_reg = line_reg;
        next_hp_reg = hp_reg;
        if (s_axi_awvalid && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = `LGH_RESP_OKAY;
            case (aw_addr)
                `LGH_ADDR_LINE_GAIN: begin
                    // Bit 7 has no storage, so it keeps reading zero.
                    if (w_strb[0]) begin
                        next_line_reg.mute =
                            w_data[`LGH_LG_MUTE_BIT];
                        next_line_reg.gain = w_data[`LGH_LG_GAIN_MSB:
                            `LGH_LG_GAIN_LSB];
                    end
                end
                `LGH_ADDR_HP_START: begin
                    if (w_strb[0]) begin
                        next_hp_reg.step_sel = w_data[`LGH_HP_STEP_MSB:
                            `LGH_HP_STEP_LSB];
                        next_hp_reg.slow_sel = w_data[`LGH_HP_SLOW_MSB:
                            `LGH_HP_SLOW_LSB];
                        next_hp_reg.rchg_sel = w_data[`LGH_HP_RCHG_MSB:
                            `LGH_HP_RCHG_LSB];
                    end
                end
                `LGH_ADDR_RSVD: begin
                    next_bresp = `LGH_RESP_OKAY;
                end
                default: begin
                    next_bresp = `LGH_RESP_SLVERR;
                end
            endcase
        end
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        next_awready = !next_aw_held;
        next_wready = !next_w_held;
    end

    always_comb begin
        next_rd_state = rd_state;
        next_rdata = rdata;
        next_rresp = rresp;
        case (rd_state)
            LGH_B_IDLE: begin
                if (s_axi_arvalid) begin
                    next_rd_state = LGH_B_RESP;
                    next_rdata = 32'h00000000;
                    next_rresp = `LGH_RESP_OKAY;
                    case (s_axi_araddr)
                        `LGH_ADDR_LINE_GAIN: begin
                            next_rdata[7:0] =
                                {1'b0, line_reg.mute, line_reg.gain};
                        end
                        `LGH_ADDR_HP_START: begin
                            next_rdata[7:0] = hp_reg;
                        end
                        `LGH_ADDR_RSVD: begin
                            next_rdata[7:0] = `LGH_RST_RSVD;
                        end
                        default: begin
                            next_rresp = `LGH_RESP_SLVERR;
                        end
                    endcase
                end
            end
            LGH_B_RESP: begin
                if (s_axi_rready) begin
                    next_rd_state = LGH_B_IDLE;
                end
            end
            default: begin
                next_rd_state = LGH_B_IDLE;
            end
        endcase
        next_arready = (next_rd_state == LGH_B_IDLE);
        next_rvalid = (next_rd_state == LGH_B_RESP);
    end

    // Soft-routing step timer: 50, 100 or 200 ms for codes 01, 10, 11; code 00 stops it.
    always_comb begin
        case (lgh_step_t'(hp_reg.step_sel))
            LGH_STEP_50: step_len = STEP_W'(STEP_CYC);
            LGH_STEP_100: step_len = STEP_W'(2 * STEP_CYC);
            LGH_STEP_200: step_len = STEP_W'(4 * STEP_CYC);
            default: step_len = '0;
        endcase
        next_step_tick = 1'b0;
        next_step_cnt = step_cnt;
        if (step_len == '0) begin
            next_step_cnt = '0;
        end else if (step_cnt >= step_len - 1'b1) begin
            next_step_cnt = '0;
            next_step_tick = 1'b1;
        end else begin
            next_step_cnt = step_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            line_reg.mute <= `LGH_RST_MUTE;
            line_reg.gain <= `LGH_RST_GAIN;
            hp_reg.step_sel <= `LGH_RST_STEP;
            hp_reg.slow_sel <= `LGH_RST_SLOW;
            hp_reg.rchg_sel <= `LGH_RST_RCHG;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `LGH_RESP_OKAY;
            rd_state <= LGH_B_IDLE;
            rdata <= 32'h00000000;
            rresp <= `LGH_RESP_OKAY;
            awready <= 1'b1;
            wready <= 1'b1;
            arready <= 1'b1;
            rvalid <= 1'b0;
            step_cnt <= '0;
            step_tick <= 1'b0;
        end else begin
            line_reg <= next_line_reg;
            hp_reg <= next_hp_reg;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rd_state <= next_rd_state;
            rdata <= next_rdata;
            rresp <= next_rresp;
            awready <= next_awready;
            wready <= next_wready;
            arready <= next_arready;
            rvalid <= next_rvalid;
            step_cnt <= next_step_cnt;
            step_tick <= next_step_tick;
        end
    end

    assign s_axi_awready = awready;
    assign s_axi_wready = wready;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_arready = arready;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;
    assign right_line_output_mute = line_reg.mute;
    assign right_line_output_gain = line_reg.gain;
    assign hp_step_sel = hp_reg.step_sel;
    assign hp_slow_sel = hp_reg.slow_sel;
    assign hp_rchg_sel = hp_reg.rchg_sel;
    assign soft_step_tick = step_tick;

    a_mute_reset: assert property (@(posedge clk_sys)
        $rose(arst_n) |-> right_line_output_mute)
        else $error("Mute not set after reset.");

    a_write_lands: assert property (@(posedge clk_sys)
        disable iff (!arst_n)
        do_write && aw_addr == `LGH_ADDR_LINE_GAIN && w_strb[0]
        |=> right_line_output_gain ==
            $past(w_data[`LGH_LG_GAIN_MSB:`LGH_LG_GAIN_LSB])
            && right_line_output_mute == $past(w_data[`LGH_LG_MUTE_BIT]))
        else $error("Line gain write not stored.");

    // Of the two stored registers only line gain has bit 7 reserved; start-up reads may set it.
    a_rsvd_bit_zero: assert property (@(posedge clk_sys)
        disable iff (!arst_n)
        s_axi_arvalid && s_axi_arready
            && s_axi_araddr == `LGH_ADDR_LINE_GAIN
        |=> s_axi_rvalid && !s_axi_rdata[`LGH_LG_RSVD_BIT])
        else $error("Reserved bit read as one.");

    a_rsvd_reg_zero: assert property (@(posedge clk_sys)
        disable iff (!arst_n)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `LGH_ADDR_RSVD
        |=> s_axi_rvalid && s_axi_rdata == 32'h00000000)
        else $error("Reserved register read nonzero.");

    a_hp_write: assert property (@(posedge clk_sys)
        disable iff (!arst_n)
        do_write && aw_addr == `LGH_ADDR_HP_START && w_strb[0]
        |=> {hp_step_sel, hp_slow_sel, hp_rchg_sel} == $past(w_data[7:0]))
        else $error("Start-up write not stored.");

    a_hp_readback: assert property (@(posedge clk_sys)
        disable iff (!arst_n)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `LGH_ADDR_HP_START
        |=> s_axi_rdata[7:0] == $past(hp_reg))
        else $error("Start-up readback wrong.");

    a_gain_read: assert property (@(posedge clk_sys)
        disable iff (!arst_n)
        s_axi_arvalid && s_axi_arready
            && s_axi_araddr == `LGH_ADDR_LINE_GAIN
        |=> s_axi_rdata[5:0] == $past(line_reg.gain))
        else $error("Gain readback wrong.");

    a_step_off: assert property (@(posedge clk_sys)
        disable iff (!arst_n)
        hp_step_sel == `LGH_RST_STEP ##1 hp_step_sel == `LGH_RST_STEP
        |-> !soft_step_tick)
        else $error("Step tick with zero step time.");

endmodule

// [verif/lgh_regs_tb_top.sv]
// Self-checking bench for the line gain and headphone start-up registers.
// Assumes the register map header and package are compiled first.
`include "lgh_regs_map.svh"
`timescale 1ns/10ps
module lgh_regs_tb_top;
    import lgh_pkg::*;
    // Printed offsets are register indices; the byte address is four times.
    localparam logic [7:0] A_LG = 8'(`LGH_OFF_LINE_GAIN * 4);
    localparam logic [7:0] A_HP = 8'(`LGH_OFF_HP_START * 4);
    localparam logic [7:0] A_RS = 8'(`LGH_OFF_RSVD * 4);
    localparam logic [7:0] A_BAD = 8'h40;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, right_line_output_mute, soft_step_tick;
    logic [1:0] s_axi_bresp, s_axi_rresp, hp_step_sel, hp_rchg_sel;
    logic [31:0] s_axi_rdata;
    logic [5:0] right_line_output_gain;
    logic [3:0] hp_slow_sel;
    int fails = 0;
    int n_tests = 0;
    int seed = 32'h77D6BCC0;
    logic [7:0] sh_lg = 8'h40;
    logic [7:0] sh_hp = 8'h00;
    logic [7:0] tbl [4] = '{A_LG, A_HP, A_RS, A_BAD};
    logic [7:0] corner [5] = '{8'hBA, 8'h1D, 8'h00, 8'h7F, 8'h3A};

    always #20 clk_sys = ~clk_sys;

    lgh_regs dut_u (.clk_sys, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .right_line_output_mute,
        .right_line_output_gain, .hp_step_sel, .hp_slow_sel, .hp_rchg_sel,
        .soft_step_tick);

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [1:0] r);
        bit aw;
        bit w;
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk_sys);
            if (!aw && s_axi_awready === 1'b1) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready === 1'b1) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk_sys);
    endtask

    function automatic logic [1:0] resp_of(input logic [7:0] a);
        return (a == A_LG || a == A_HP || a == A_RS) ? `LGH_RESP_OKAY
                                                     : `LGH_RESP_SLVERR;
    endfunction

    // Writes one register and keeps the bench's own copy of its contents.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        logic [1:0] r;
        axi_wr(a, d, s, r);
        chk(32'(r), 32'(resp_of(a)));
        if (s[0] && a == A_LG) sh_lg = {1'b0, d[6:0]};
        if (s[0] && a == A_HP) sh_hp = d[7:0];
    endtask

    task automatic check_all();
        logic [31:0] v;
        logic [1:0] r;
        axi_rd(A_LG, v, r);
        chk(v, {24'h0, sh_lg});
        axi_rd(A_HP, v, r);
        chk(v, {24'h0, sh_hp});
        axi_rd(A_RS, v, r);
        chk(v, 32'(`LGH_RST_RSVD));
        chk(32'(right_line_output_mute), 32'(sh_lg[6]));
        chk(32'(right_line_output_gain), 32'(sh_lg[5:0]));
        chk(32'(hp_step_sel), 32'(sh_hp[7:6]));
        chk(32'(hp_slow_sel), 32'(sh_hp[5:2]));
        chk(32'(hp_rchg_sel), 32'(sh_hp[1:0]));
        // The shortest step period far outlasts the run, so no tick is due.
        chk(32'(soft_step_tick), 32'h0);
    endtask

    initial begin
        logic [31:0] rv;
        logic [31:0] d;
        logic [31:0] v;
        logic [1:0] r;
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        check_all();
        foreach (corner[i]) begin
            wr(A_LG, {24'h0, corner[i]}, 4'hF);
            check_all();
        end
        for (int i = 0; i < 16; i++) begin
            // The two longest ramps never go with the weakest charging.
            d = {24'h0, i[1:0], i[3:0], (i >= 14) ? 2'h1 : 2'(i % 3)};
            wr(A_HP, d, 4'hF);
            check_all();
        end
        wr(A_RS, 32'h0000_00A5, 4'hF);
        wr(A_LG, 32'h0000_0015, 4'h0);
        check_all();
        repeat (30) begin
            rv = $random(seed);
            d = $random(seed);
            // Gain codes in the forbidden range 0x1E to 0x39 are folded back to legal.
            if (d[5:0] >= 6'h1E && d[5:0] <= 6'h39) d[5:0] -= 6'h1E;
            d[7] = 1'b0;
            if (rv[1:0] == 2'h1) d[1:0] = 2'(d[9:8] % 3);
            if (rv[1:0] == 2'h1 && d[1:0] == 2'h0) d[5] = 1'b0;
            if (rv[1:0] == 2'h2) d = 32'h0;
            wr(tbl[rv[1:0]], d, (rv[4:2] == 3'h0) ? 4'h0 : 4'hF);
            check_all();
        end
        // A reset in mid-run must bring every field back to its default.
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        sh_lg = 8'h40;
        sh_hp = 8'h00;
        @(posedge clk_sys);
        check_all();
        axi_rd(A_BAD, v, r);
        chk(v, 32'h0);
        chk(32'(r), 32'(`LGH_RESP_SLVERR));
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        wrap_up();
    end
endmodule
